// ### nfc_cfg.svh
// constants for the nand flash host controller
`ifndef NFC_CFG_SVH
`define NFC_CFG_SVH

// command codes
`define NFC_CMD_READ      8'h00
`define NFC_CMD_READ_GO   8'h30
`define NFC_CMD_RCOL      8'h05
`define NFC_CMD_RCOL_GO   8'he0
`define NFC_CMD_RCACHE    8'h31
`define NFC_CMD_RLAST     8'h3f
`define NFC_CMD_DIN       8'h80
`define NFC_CMD_DIN_M     8'h81
`define NFC_CMD_WCOL      8'h85
`define NFC_CMD_PROG      8'h10
`define NFC_CMD_PROG_M    8'h11
`define NFC_CMD_PROG_C    8'h15
`define NFC_CMD_COPY_RD   8'h3a
`define NFC_CMD_COPY_WR   8'h8c
`define NFC_CMD_ERASE     8'h60
`define NFC_CMD_ERASE_GO  8'hd0
`define NFC_CMD_ID        8'h90
`define NFC_CMD_STATUS    8'h70
`define NFC_CMD_STATUS_M  8'h71
`define NFC_CMD_RESET     8'hff

// geometry and address layout
`define NFC_PAGE_BYTES    2176
`define NFC_MAIN_BYTES    2048
`define NFC_SPARE_BYTES   128
`define NFC_BLOCK_PAGES   64
`define NFC_COL_W         12
`define NFC_ROW_W         17
`define NFC_ADDR_LAST     3'h4
`define NFC_COL_LAST      3'h1
`define NFC_ROW_FIRST     3'h2

// status byte bits
`define NFC_ST_RDY_BIT    6
`define NFC_ST_FAIL_BIT   1

// timing, figures in ns, counts in core_clk cycles rounded up
`define NFC_CLK_NS        50
`define NFC_CYC_MIN(ns)   (((ns) + `NFC_CLK_NS - 1) / `NFC_CLK_NS)
`define NFC_T_WP_NS       12
`define NFC_T_WH_NS       10
`define NFC_T_RP_NS       12
`define NFC_T_REH_NS      10
`define NFC_T_WHR_NS      60
`define NFC_T_WB_NS       100
`define NFC_WP_CYC        `NFC_CYC_MIN(`NFC_T_WP_NS)
`define NFC_WH_CYC        `NFC_CYC_MIN(`NFC_T_WH_NS)
`define NFC_RP_CYC        `NFC_CYC_MIN(`NFC_T_RP_NS)
`define NFC_REH_CYC       `NFC_CYC_MIN(`NFC_T_REH_NS)
`define NFC_WHR_CYC       `NFC_CYC_MIN(`NFC_T_WHR_NS)
`define NFC_WB_CYC        `NFC_CYC_MIN(`NFC_T_WB_NS)

`endif

// ### nfc_pkg.sv
// types and helper functions for the nand flash host controller
`include "nfc_cfg.svh"
package nfc_pkg;

   // one bus transaction kind per request
   typedef enum logic [2:0] {
      op_cmd, op_addr5, op_acol, op_arow, op_dwr, op_drd, op_wait
   } nfc_op_t;

   typedef enum logic [2:0] {
      st_idle, st_setup, st_wlow, st_whigh, st_rlow, st_rhigh, st_wb, st_wrdy
   } nfc_state_t;

   function automatic logic nfc_is_addr(input nfc_op_t k);
      return (k == op_addr5) || (k == op_acol) || (k == op_arow);
   endfunction

   // codes the device still takes while it is busy
   function automatic logic nfc_busy_ok(input logic [7:0] b);
      return (b == `NFC_CMD_STATUS) || (b == `NFC_CMD_STATUS_M) || (b == `NFC_CMD_RESET);
   endfunction

   function automatic logic [2:0] nfc_last_idx(input nfc_op_t k);
      logic [2:0] r;
      r = 3'h0;
      if (k == op_addr5 || k == op_arow) begin
         r = `NFC_ADDR_LAST;
      end else if (k == op_acol) begin
         r = `NFC_COL_LAST;
      end
      return r;
   endfunction

endpackage

// ### nfc_addr_byte.sv
// picks one byte of the five-cycle column/row address
`timescale 1ns/100ps
`include "nfc_cfg.svh"
module nfc_addr_byte
   import nfc_pkg::*;
(
   input  wire logic [`NFC_COL_W-1:0] col,
   input  wire logic [`NFC_ROW_W-1:0] row,
   input  wire logic [2:0]            idx,
   output logic      [7:0]            addr_byte
);

   // column first, then row; unused high bits go out low
   always_comb begin
      unique case (idx)
         3'h0:    addr_byte = col[7:0];
         3'h1:    addr_byte = {4'h0, col[11:8]};
         3'h2:    addr_byte = row[7:0];
         3'h3:    addr_byte = row[15:8];
         3'h4:    addr_byte = {7'h00, row[16]};
         default: addr_byte = 8'h00;
      endcase
   end

endmodule

// ### nfc_host.sv
// host side sequencer driving the nand flash strobes and shared bus
`timescale 1ns/100ps
`include "nfc_cfg.svh"
module nfc_host
   import nfc_pkg::*;
(
   input  wire logic                  core_clk,
   input  wire logic                  reset_n,
   input  wire logic                  op_valid,
   output logic                       op_ready,
   input  wire nfc_op_t               op_kind,
   input  wire logic [7:0]            op_byte,
   input  wire logic [`NFC_COL_W-1:0] op_col,
   input  wire logic [`NFC_ROW_W-1:0] op_row,
   input  wire logic                  protect,
   output logic                       rd_valid,
   output logic [7:0]                 rd_data,
   output logic [`NFC_COL_W-1:0]      rd_col,
   output logic                       stat_ready,
   output logic                       stat_fail,
   output logic                       dev_busy,
   output logic                       cle,
   output logic                       ale,
   output logic                       ce_n,
   output logic                       we_n,
   output logic                       re_n,
   output logic                       wp_n,
   output logic [7:0]                 io_out,
   output logic                       io_oe_n,
   input  wire logic [7:0]            io_in,
   input  wire logic                  ready_busy_n
);

   localparam logic [3:0] WP_CYC  = 4'(`NFC_WP_CYC);
   localparam logic [3:0] WH_CYC  = 4'(`NFC_WH_CYC);
   localparam logic [3:0] RP_CYC  = 4'(`NFC_RP_CYC);
   localparam logic [3:0] REH_CYC = 4'(`NFC_REH_CYC);
   localparam logic [3:0] WHR_CYC = 4'(`NFC_WHR_CYC);
   localparam logic [3:0] WB_CYC  = 4'(`NFC_WB_CYC);
   localparam logic [`NFC_COL_W-1:0] COL_END = `NFC_COL_W'(`NFC_PAGE_BYTES - 1);

   nfc_state_t              state_q, state_d;
   nfc_op_t                 kind_q, kind_d;
   logic [3:0]              cnt_q, cnt_d;
   logic [2:0]              idx_q, idx_d;
   logic [3:0]              whr_q;
   logic [7:0]              byte_q, byte_d;
   logic [`NFC_COL_W-1:0]   col_q, col_d;
   logic [`NFC_ROW_W-1:0]   row_q, row_d;
   logic                    status_mode_q;
   logic                    acc;
   logic                    busy_ok;
   logic                    wr_phase;
   logic [7:0]              addr_byte;

   // the pin is used without a synchroniser; low means the device is working
   assign dev_busy = ~ready_busy_n;

   // while busy only status, reset, status data and waits go out
   assign busy_ok  = (op_kind == op_wait) ||
                     (op_kind == op_cmd && nfc_busy_ok(op_byte)) ||
                     (op_kind == op_drd && status_mode_q);
   assign op_ready = (state_q == st_idle) && (!dev_busy || busy_ok);
   assign acc      = op_valid && op_ready;

   // request fields seen by the pin registers in the accept cycle
   assign byte_d = acc ? op_byte : byte_q;
   assign col_d  = acc ? op_col  : col_q;
   assign row_d  = acc ? op_row  : row_q;

   nfc_addr_byte u_addr (
      .col       (col_d),
      .row       (row_d),
      .idx       (idx_d),
      .addr_byte (addr_byte)
   );

   // next state of the bus cycle sequencer
   always_comb begin
      state_d = state_q;
      kind_d  = kind_q;
      cnt_d   = cnt_q;
      idx_d   = idx_q;
      unique case (state_q)
         st_idle: begin
            if (acc) begin
               kind_d = op_kind;
               idx_d  = (op_kind == op_arow) ? `NFC_ROW_FIRST : 3'h0;
               cnt_d  = 4'h0;
               if (op_kind == op_wait) begin
                  state_d = st_wb;
                  cnt_d   = WB_CYC - 4'h1;
               end else begin
                  state_d = st_setup;
               end
            end
         end
         st_setup: begin
            if (kind_q == op_drd) begin
               // hold off the read strobe until write-to-read spacing is met
               if (whr_q == 4'h0) begin
                  state_d = st_rlow;
                  cnt_d   = RP_CYC - 4'h1;
               end
            end else begin
               state_d = st_wlow;
               cnt_d   = WP_CYC - 4'h1;
            end
         end
         st_wlow: begin
            if (cnt_q == 4'h0) begin
               state_d = st_whigh;
               cnt_d   = WH_CYC - 4'h1;
            end else begin
               cnt_d = cnt_q - 4'h1;
            end
         end
         st_whigh: begin
            if (cnt_q != 4'h0) begin
               cnt_d = cnt_q - 4'h1;
            end else if (idx_q == nfc_last_idx(kind_q)) begin
               state_d = st_idle;
            end else begin
               idx_d   = idx_q + 3'h1;
               state_d = st_setup;
            end
         end
         st_rlow: begin
            if (cnt_q == 4'h0) begin
               state_d = st_rhigh;
               cnt_d   = REH_CYC - 4'h1;
            end else begin
               cnt_d = cnt_q - 4'h1;
            end
         end
         st_rhigh: begin
            if (cnt_q == 4'h0) begin
               state_d = st_idle;
            end else begin
               cnt_d = cnt_q - 4'h1;
            end
         end
         st_wb: begin
            // busy may not show until the write-to-busy delay has passed
            if (cnt_q == 4'h0) begin
               state_d = st_wrdy;
            end else begin
               cnt_d = cnt_q - 4'h1;
            end
         end
         st_wrdy: begin
            if (ready_busy_n) begin
               state_d = st_idle;
            end
         end
      endcase
   end

   // sequencer and request registers
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         state_q <= st_idle;
         kind_q  <= op_cmd;
         cnt_q   <= 4'h0;
         idx_q   <= 3'h0;
         byte_q  <= 8'h00;
         col_q   <= '0;
         row_q   <= '0;
      end else begin
         state_q <= state_d;
         kind_q  <= kind_d;
         cnt_q   <= cnt_d;
         idx_q   <= idx_d;
         byte_q  <= byte_d;
         col_q   <= col_d;
         row_q   <= row_d;
      end
   end

   // spacing from the last write strobe rise to the next read fall
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         whr_q <= 4'h0;
      end else if (state_q == st_wlow && state_d == st_whigh) begin
         whr_q <= WHR_CYC;
      end else if (whr_q != 4'h0) begin
         whr_q <= whr_q - 4'h1;
      end
   end

   // pins come from flops so strobes never glitch
   assign wr_phase = (state_d == st_setup || state_d == st_wlow || state_d == st_whigh) &&
                     kind_d != op_drd;
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         cle     <= 1'b0;
         ale     <= 1'b0;
         ce_n    <= 1'b1;
         we_n    <= 1'b1;
         re_n    <= 1'b1;
         io_oe_n <= 1'b1;
         io_out  <= 8'h00;
      end else begin
         cle     <= wr_phase && kind_d == op_cmd;
         ale     <= wr_phase && nfc_is_addr(kind_d);
         // deselect when idle: standby while ready, harmless while busy
         ce_n    <= state_d == st_idle || state_d == st_wb || state_d == st_wrdy;
         we_n    <= state_d != st_wlow;
         re_n    <= state_d != st_rlow;
         io_oe_n <= !wr_phase;
         io_out  <= nfc_is_addr(kind_d) ? addr_byte : byte_d;
      end
   end

   // read capture at the end of the low read pulse
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         rd_valid <= 1'b0;
         rd_data  <= 8'h00;
      end else begin
         rd_valid <= state_q == st_rlow && cnt_q == 4'h0;
         if (state_q == st_rlow && cnt_q == 4'h0) begin
            rd_data <= io_in;
         end
      end
   end

   // mirror of the device column counter; wraps at the page end
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         rd_col <= '0;
      end else if (state_q == st_whigh && cnt_q == 4'h0 && idx_q == `NFC_COL_LAST &&
                   (kind_q == op_addr5 || kind_q == op_acol)) begin
         rd_col <= col_q;
      end else if (state_q == st_rlow && cnt_q == 4'h0 && !status_mode_q) begin
         rd_col <= (rd_col == COL_END) ? '0 : rd_col + 1'b1;
      end
   end

   // status mode follows the last command written
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         status_mode_q <= 1'b0;
      end else if (state_q == st_wlow && kind_q == op_cmd) begin
         status_mode_q <= byte_q == `NFC_CMD_STATUS || byte_q == `NFC_CMD_STATUS_M;
      end
   end

   // decoded status bits from each status byte read
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         stat_ready <= 1'b0;
         stat_fail  <= 1'b0;
      end else if (state_q == st_rlow && cnt_q == 4'h0 && status_mode_q) begin
         stat_ready <= io_in[`NFC_ST_RDY_BIT];
         stat_fail  <= io_in[`NFC_ST_FAIL_BIT];
      end
   end

   // protect only changes while idle and ready, never inside an operation
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         wp_n <= 1'b0;
      end else if (state_q == st_idle && !acc && !dev_busy) begin
         wp_n <= !protect;
      end
   end

endmodule

// ### nfc_host_monitor.sv
// checker on the nand flash host pins and request port
`timescale 1ns/100ps
module nfc_host_monitor
   import nfc_pkg::*;
(
   input wire logic       core_clk,
   input wire logic       reset_n,
   input wire logic       op_valid,
   input wire logic       op_ready,
   input wire nfc_op_t    op_kind,
   input wire logic [7:0] op_byte,
   input wire logic       protect,
   input wire logic       rd_valid,
   input wire logic       cle,
   input wire logic       ale,
   input wire logic       ce_n,
   input wire logic       we_n,
   input wire logic       re_n,
   input wire logic       wp_n,
   input wire logic [7:0] io_out,
   input wire logic       io_oe_n,
   input wire logic       ready_busy_n
);
   logic [2:0] abyte_q;
   nfc_op_t    kind_q;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   // address bytes since ale rose, and the kind of the last request taken
   always_ff @(posedge core_clk) begin
      if (!reset_n || !ale) begin
         abyte_q <= 3'h0;
      end else if ($rose(we_n)) begin
         abyte_q <= abyte_q + 3'h1;
      end
   end
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         kind_q <= op_cmd;
      end else if (op_valid && op_ready) begin
         kind_q <= op_kind;
      end
   end
   a_write_levels: assert property ($rose(we_n) |-> !(cle && ale) && !ce_n && re_n && !io_oe_n)
      else $error("write strobe rose with bad latch levels");
   a_col_high: assert property ($rose(we_n) && ale && abyte_q == 3'h1 && kind_q != op_arow
      |-> io_out[7:4] == 4'h0) else $error("column high byte not zero on top");
   a_row_top: assert property ($rose(we_n) && ale
      && abyte_q == ((kind_q == op_arow) ? 3'h2 : 3'h4) |-> io_out[7:1] == 7'h00)
      else $error("last row byte carries more than one bit");
   a_addr_count: assert property ($fell(ale) |-> abyte_q == ((kind_q == op_addr5) ? 3'h5 :
      (kind_q == op_acol) ? 3'h2 : 3'h3)) else $error("wrong number of address cycles");
   a_busy_writes: assert property (!ready_busy_n && !we_n |-> cle
      && io_out inside {8'h70, 8'h71, 8'hff}) else $error("write while busy");
   a_busy_take: assert property (!ready_busy_n && op_valid && op_ready |-> op_kind inside {op_wait,
      op_drd} || (op_kind == op_cmd && op_byte inside {8'h70, 8'h71, 8'hff}))
      else $error("request taken while busy");
   a_wp_busy: assert property (!ready_busy_n |-> $stable(wp_n))
      else $error("protect pin moved while busy");
   a_wp_follow: assert property (protect && ready_busy_n && op_ready |-> ##[1:2] !wp_n)
      else $error("protect pin did not follow");
   a_read_pulse: assert property ($fell(re_n) |=> re_n && rd_valid)
      else $error("read strobe without data pulse");
   a_read_levels: assert property (!re_n |-> !cle && !ale && !ce_n && we_n && io_oe_n)
      else $error("read strobe low with bad levels");
   a_idle_standby: assert property (op_ready |-> ce_n && we_n && re_n)
      else $error("select held while idle");
endmodule
bind nfc_host nfc_host_monitor u_mon (.core_clk(core_clk), .reset_n(reset_n),
   .op_valid(op_valid), .op_ready(op_ready), .op_kind(op_kind), .op_byte(op_byte),
   .protect(protect), .rd_valid(rd_valid), .cle(cle), .ale(ale), .ce_n(ce_n), .we_n(we_n),
   .re_n(re_n), .wp_n(wp_n), .io_out(io_out), .io_oe_n(io_oe_n), .ready_busy_n(ready_busy_n));

// ### nfc_dev_model.sv
// behavioural nand flash device on the far side of the host
`timescale 1ns/100ps
module nfc_dev_model (
   input  wire logic       cle,
   input  wire logic       ale,
   input  wire logic       ce_n,
   input  wire logic       we_n,
   input  wire logic       re_n,
   input  wire logic       wp_n,
   input  wire logic [7:0] bus,
   output logic [7:0]      dout,
   output logic            dout_en,
   output logic            ready_busy_n
);
   localparam int BUSY_NS = 2000; // long enough to poll status inside
   logic [7:0]  cmd_q = 8'h00; // power-on read preset
   logic [2:0]  acnt_q = 3'h0;
   logic [11:0] col_q = 12'h000;
   logic [16:0] row_q = 17'h00000;
   logic        stat_q = 1'b0;
   logic        fail_q = 1'b0; // sticky until reset: an inhibited program or erase failed
   realtime     end_t = 0;
   initial begin
      dout = 8'h00;
      dout_en = 1'b0;
      ready_busy_n = 1'b1;
   end
   // one shared bus, meaning chosen by latch strobes at write rise
   always @(posedge we_n) begin
      if (!ce_n && cle && (ready_busy_n || bus inside {8'h70, 8'h71, 8'hff})) begin
         cmd_q <= bus;
         acnt_q <= (bus == 8'h60) ? 3'h2 : 3'h0;
         stat_q <= bus inside {8'h70, 8'h71};
         if (bus == 8'hff) begin
            ready_busy_n <= 1'b1;
            fail_q <= 1'b0;
         end
         if (!wp_n && bus inside {8'h10, 8'hd0}) begin
            fail_q <= 1'b1;
         end
         if (bus == 8'h30 || (wp_n && bus inside {8'h10, 8'hd0})) begin
            ready_busy_n <= 1'b0;
            end_t = $realtime + BUSY_NS;
         end
      end else if (!ce_n && ale && ready_busy_n) begin
         case (acnt_q)
            3'h0: col_q[7:0] <= bus;
            3'h1: col_q[11:8] <= bus[3:0];
            3'h2: row_q[7:0] <= bus;
            3'h3: row_q[15:8] <= bus;
            default: row_q[16] <= bus[0];
         endcase
         acnt_q <= acnt_q + 3'h1;
      end
   end
   // busy ends after a fixed time or at once on a reset command; select is ignored meanwhile
   always #10 begin
      if (!ready_busy_n && $realtime >= end_t) begin
         ready_busy_n = 1'b1;
      end
   end
   // next byte on each read fall; column moves on except in status mode
   always @(negedge re_n) begin
      if (!ce_n && !cle && !ale && we_n) begin
         dout <= stat_q ? {wp_n, ready_busy_n, 4'h0, fail_q, 1'b0} : col_q[7:0] ^ row_q[7:0];
         dout_en <= 1'b1;
         if (!stat_q) begin
            col_q <= (col_q == 12'h87f) ? 12'h000 : col_q + 12'h001;
         end
      end
   end
   // bus released as soon as read strobe or select rises
   always @(posedge re_n or posedge ce_n) begin
      dout_en <= 1'b0;
   end
endmodule

// ### tb_top.sv
// self-checking bench for the nand flash host controller
`timescale 1ns/100ps
module tb_top
   import nfc_pkg::*;
;
   logic        core_clk = 1'b0, reset_n = 1'b0, op_valid = 1'b0, protect = 1'b0;
   nfc_op_t     op_kind = op_cmd;
   logic [7:0]  op_byte = 8'h00, rd_data, io_out, io_in, dout;
   logic [11:0] op_col = 12'h000, rd_col;
   logic [16:0] op_row = 17'h00000;
   logic        op_ready, rd_valid, stat_ready, stat_fail, dev_busy, cle, ale, ce_n;
   logic        we_n, re_n, wp_n, io_oe_n, dout_en, ready_busy_n;
   int          mismatches = 0, check_count = 0;
   always #25 core_clk = ~core_clk;
   // no pull-up on the data lines: an undriven bus shows the inverse
   assign io_in = !io_oe_n ? io_out : (dout_en ? dout : ~dout);
   nfc_host uut (.core_clk(core_clk), .reset_n(reset_n), .op_valid(op_valid),
      .op_ready(op_ready), .op_kind(op_kind), .op_byte(op_byte), .op_col(op_col),
      .op_row(op_row), .protect(protect), .rd_valid(rd_valid), .rd_data(rd_data),
      .rd_col(rd_col), .stat_ready(stat_ready), .stat_fail(stat_fail), .dev_busy(dev_busy),
      .cle(cle), .ale(ale), .ce_n(ce_n), .we_n(we_n), .re_n(re_n), .wp_n(wp_n),
      .io_out(io_out), .io_oe_n(io_oe_n), .io_in(io_in), .ready_busy_n(ready_busy_n));
   nfc_dev_model u_dev (.cle(cle), .ale(ale), .ce_n(ce_n), .we_n(we_n), .re_n(re_n),
      .wp_n(wp_n), .bus(io_out), .dout(dout), .dout_en(dout_en), .ready_busy_n(ready_busy_n));
   task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // hold a request until taken; a hang counts as a mismatch
   task automatic do_op(input nfc_op_t k, input logic [7:0] b, input logic [11:0] c = 12'h000,
                        input logic [16:0] r = 17'h00000);
      int n;
      n = 0;
      @(posedge core_clk);
      op_kind <= k;
      op_byte <= b;
      op_col <= c;
      op_row <= r;
      op_valid <= 1'b1;
      @(negedge core_clk);
      while (op_ready !== 1'b1) begin
         n++;
         if (n > 2000) begin
            chk(1'b0, 1'b1);
            results();
         end
         @(negedge core_clk);
      end
      @(posedge core_clk);
      op_valid <= 1'b0;
   endtask
   task automatic rd_wait();
      int n;
      n = 0;
      do_op(op_drd, 8'h00);
      while (rd_valid !== 1'b1 && n < 20) begin
         @(negedge core_clk);
         n++;
      end
      chk(rd_valid, 1'b1);
      if (rd_valid !== 1'b1) begin
         results();
      end
   endtask
   task automatic status(input logic exp_rdy, input logic exp_fail);
      do_op(op_cmd, 8'h70);
      rd_wait();
      chk(stat_ready, exp_rdy);
      chk(stat_fail, exp_fail);
   endtask
   task automatic t_read();
      logic [11:0] c;
      c = 12'h87e;
      do_op(op_cmd, 8'h00);
      do_op(op_addr5, 8'h00, c, 17'h10041);
      do_op(op_cmd, 8'h30);
      do_op(op_wait, 8'h00);
      for (int i = 0; i < 3; i++) begin
         rd_wait();
         chk(rd_data, c[7:0] ^ 8'h41);
         c = (c == 12'h87f) ? 12'h000 : c + 12'h001;
      end
      chk(rd_col, c);
      // column change during output: two column cycles only
      c = 12'h123;
      do_op(op_cmd, 8'h05);
      do_op(op_acol, 8'h00, c);
      do_op(op_cmd, 8'he0);
      rd_wait();
      chk(rd_data, c[7:0] ^ 8'h41);
      chk(rd_col, c + 12'h001);
      $display("test read done");
   endtask
   task automatic t_prog();
      do_op(op_cmd, 8'h80);
      do_op(op_addr5, 8'h00, 12'h010, 17'h00080);
      do_op(op_dwr, 8'h5a);
      do_op(op_cmd, 8'h10);
      status(1'b0, 1'b0);
      @(posedge core_clk);
      op_kind <= op_cmd;
      op_byte <= 8'h00;
      op_valid <= 1'b1;
      @(negedge core_clk);
      chk(op_ready, 1'b0);
      chk(dev_busy, 1'b1);
      @(posedge core_clk);
      op_valid <= 1'b0;
      do_op(op_wait, 8'h00);
      rd_wait();
      chk(stat_ready, 1'b1);
      chk(dev_busy, 1'b0);
      $display("test program done");
   endtask
   task automatic t_erase();
      for (int p = 1; p >= 0; p--) begin
         @(posedge core_clk);
         protect <= p[0];
         repeat (3) @(negedge core_clk);
         chk(wp_n, !p[0]);
         do_op(op_cmd, 8'h60);
         do_op(op_arow, 8'h00, 12'h000, 17'h1ffc0);
         do_op(op_cmd, 8'hd0);
         status(p[0], 1'b1);
      end
      do_op(op_cmd, 8'hff);
      status(1'b1, 1'b0);
      $display("test erase done");
   endtask
   task automatic t_codes();
      logic [7:0] codes [17] = '{8'h00, 8'h30, 8'h05, 8'he0, 8'h31, 8'h3f, 8'h80, 8'h85,
                                 8'h10, 8'h15, 8'h11, 8'h81, 8'h3a, 8'h8c, 8'h60, 8'hd0, 8'h90};
      foreach (codes[i]) begin
         do_op(op_cmd, codes[i]);
         do_op(op_wait, 8'h00);
         chk(u_dev.cmd_q, codes[i]);
      end
      $display("test codes done");
   endtask
   initial begin
      repeat (8) @(posedge core_clk);
      reset_n <= 1'b1;
      t_read();
      t_prog();
      t_erase();
      t_codes();
      results();
   end
endmodule
